// ---- core/adcr_defines.vh ----
// Functional notes
// [RULE1] Eight-bit page selector covers pages 0 to 255.
// [RULE2] Page selector resets to zero.
// [RULE3] Soft reset bit starts reset, self clears.
// [RULE4] Bit 7 picks brownout input and lockout.
// [RULE5] Source zero gives 2.75 V default thresholds.
// [RULE6] Bit 4 powers down current sense, reset one.
// [RULE7] Bit 3 powers down voltage sense, reset one.
// [RULE8] Mode field decodes active, mute, shutdown, generator.
// [RULE9] Mode 011 runs diagnostic then powers up.
// [RULE10] Mode 100 diagnostic then rewrites field to 010.
// [RULE11] Mode register resets to 1a.
// [RULE12] Software changes configuration only during shutdown.
// [RULE13] Page selector reachable on every page.
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH
// Byte addresses of the registers on the bus.
`define ADCR_OFS_PAGE      8'h00
`define ADCR_OFS_SRST      8'h04
`define ADCR_OFS_MODE      8'h08
// Register indices within a page.
`define ADCR_IDX_PAGE      6'h00
`define ADCR_IDX_SRST      6'h01
`define ADCR_IDX_MODE      6'h02
// Reset values.
`define ADCR_RST_PAGE      8'h00
`define ADCR_RST_MODE      8'h1a
// Field positions in the mode register.
`define ADCR_BIT_BSRC      7
`define ADCR_BIT_ISNS      4
`define ADCR_BIT_VSNS      3
// Mode codes.
`define ADCR_M_ACTIVE      3'h0
`define ADCR_M_MUTE        3'h1
`define ADCR_M_SHDN        3'h2
`define ADCR_M_DIAG_UP     3'h3
`define ADCR_M_DIAG_ONLY   3'h4
`define ADCR_M_GEN         3'h5
// Default brownout threshold in millivolts.
`define ADCR_BOP_DEF_MV    12'd2750
// Length of the soft reset pulse in clock cycles.
`define ADCR_SRST_CYCLES   4'd8
`endif

// ---- core/adcr_diag.v ----
`timescale 1ns/1ps
// Sequences one load diagnostic against an external measuring engine.
module adcr_diag (
    // Clock and reset.
    input  wire clock,
    input  wire rst_n,
    // Start pulse and engine handshake.
    input  wire start,
    input  wire diag_done,
    output reg  running,
    output reg  finished
);
    // Running flag holds from start until the engine reports done.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            running  <= 1'b0;
            finished <= 1'b0;
        end
        else
        begin
            finished <= running & diag_done;
            if (start)
                running <= 1'b1;
            else if (diag_done)
                running <= 1'b0;
        end
    end
endmodule // adcr_diag

// ---- core/adcr_pulse.v ----
`timescale 1ns/1ps
// Stretches a one-cycle trigger into a pulse of a fixed length.
module adcr_pulse #(
    parameter LEN = 8
) (
    // Clock and reset.
    input  wire clock,
    input  wire rst_n,
    // Trigger and stretched output.
    input  wire trig,
    output reg  busy
);
    reg [7:0] count; // Cycles left in the pulse.

    // Counter loads on a trigger and runs down to zero.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 8'h00;
            busy  <= 1'b0;
        end
        else if (trig)
        begin
            count <= LEN[7:0] - 8'h01;
            busy  <= 1'b1;
        end
        else if (count != 8'h00)
        begin
            count <= count - 8'h01;
        end
        else
        begin
            busy <= 1'b0;
        end
    end
endmodule // adcr_pulse

// ---- core/adcr_regs.v ----
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adcr_defines.vh"
// Page, soft reset and operating mode registers on an AXI4-Lite slave.
// Only page 0 is implemented here; other pages answer with zeros, and the
// page selector itself sits at the same address on every page.
module adcr_regs (
    // Clock and reset.
    input  wire        clock,
    input  wire        rst_n,
    // AXI4-Lite write address.
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [7:0]  s_axi_awaddr,
    // AXI4-Lite write data.
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address.
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [7:0]  s_axi_araddr,
    // AXI4-Lite read data.
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Load diagnostic engine.
    input  wire        diag_done,
    output wire        diag_running,
    // Controls to the rest of the device.
    output wire [7:0]  page,
    output wire        soft_reset_pulse,
    output reg         brownout_source_select,
    output reg         undervoltage_lockout_en,
    output reg  [11:0] brownout_threshold_mv,
    output reg         current_sense_powerdown,
    output reg         voltage_sense_powerdown,
    output reg         amp_active,
    output reg         amp_mute,
    output reg         amp_shutdown,
    output reg         diag_generator
);
    // Register state.
    reg  [7:0]  page_select;            // Current page.
    reg  [7:0]  operating_mode_control; // Mode register.
    reg         srst_trig;              // One-cycle soft reset request.
    reg         aw_held;                // Write address captured.
    reg         w_held;                 // Write data captured.
    reg  [7:0]  aw_addr;                // Captured write address.
    reg  [31:0] w_data;                 // Captured write data.
    reg  [3:0]  w_strb;                 // Captured byte enables.
    reg         powerup_pending;        // Power up follows diagnostic.
    wire        diag_finished;          // Diagnostic completion pulse.
    wire        srst_busy;              // Soft reset in progress.
    wire [2:0]  mode_field;             // Low three mode bits.
    wire        do_write;               // Both halves of a write present.
    wire        wr_hit_page;            // Write to the page selector.
    wire        wr_page0;               // Write lands on page 0.
    wire        start_diag;             // Diagnostic code just written.
    wire [7:0]  next_mode;              // Mode value after a write.

    assign mode_field = operating_mode_control[2:0];
    assign page = page_select;
    assign soft_reset_pulse = srst_busy;

    // Address and data are taken independently, in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit_page = do_write && (aw_addr == `ADCR_OFS_PAGE); // see [RULE13]
    assign wr_page0 = do_write && (page_select == 8'h00);
    assign next_mode = w_strb[0] ? w_data[7:0] : operating_mode_control;
    assign start_diag = wr_page0 && (aw_addr == `ADCR_OFS_MODE) && w_strb[0] &&
        ((w_data[2:0] == `ADCR_M_DIAG_UP) || (w_data[2:0] == `ADCR_M_DIAG_ONLY));

    // Capture of write address and write data.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response: unmapped addresses answer with SLVERR.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if ((aw_addr == `ADCR_OFS_PAGE) || (aw_addr == `ADCR_OFS_SRST) ||
                (aw_addr == `ADCR_OFS_MODE))
                s_axi_bresp <= 2'h0;
            else
                s_axi_bresp <= 2'h2;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Page selector; reachable whatever page is selected.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            page_select <= `ADCR_RST_PAGE; // see [RULE2]
        else if (wr_hit_page && w_strb[0])
            page_select <= w_data[7:0]; // see [RULE1]
    end

    // Soft reset trigger is a one-cycle event; the bit never stores a one.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            srst_trig <= 1'b0;
        else
            srst_trig <= wr_page0 && (aw_addr == `ADCR_OFS_SRST) &&
                w_strb[0] && w_data[0]; // see [RULE3]
    end

    adcr_pulse #(
        .LEN (`ADCR_SRST_CYCLES)
    ) u_srst (
        .clock (clock),
        .rst_n (rst_n),
        .trig  (srst_trig),
        .busy  (srst_busy)
    );

    adcr_diag u_diag (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (start_diag),
        .diag_done (diag_done),
        .running   (diag_running),
        .finished  (diag_finished)
    );

    // Mode register. The soft reset returns it to its reset value. When a
    // standalone diagnostic ends, hardware writes shutdown into the field;
    // a software write in the same cycle loses to that, since the engine
    // has just finished and shutdown is the documented end state.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operating_mode_control <= `ADCR_RST_MODE; // see [RULE11]
            powerup_pending        <= 1'b0;
        end
        else if (srst_busy)
        begin
            operating_mode_control <= `ADCR_RST_MODE; // see [RULE3]
            powerup_pending        <= 1'b0;
        end
        else
        begin
            if (wr_page0 && (aw_addr == `ADCR_OFS_MODE))
                operating_mode_control <= next_mode;
            if (diag_finished && (mode_field == `ADCR_M_DIAG_ONLY))
                operating_mode_control[2:0] <= `ADCR_M_SHDN; // see [RULE10]
            if (start_diag)
                powerup_pending <= (w_data[2:0] == `ADCR_M_DIAG_UP);
            else if (diag_finished)
                powerup_pending <= 1'b0;
        end
    end

    // Decoded controls, registered. Software is expected to reconfigure
    // only in shutdown; the block does not police that (see [RULE12]).
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brownout_source_select  <= 1'b0;
            undervoltage_lockout_en <= 1'b0;
            brownout_threshold_mv   <= `ADCR_BOP_DEF_MV;
            current_sense_powerdown <= 1'b1;
            voltage_sense_powerdown <= 1'b1;
            amp_active              <= 1'b0;
            amp_mute                <= 1'b0;
            amp_shutdown            <= 1'b1;
            diag_generator          <= 1'b0;
        end
        else
        begin
            brownout_source_select  <= operating_mode_control[`ADCR_BIT_BSRC]; // see [RULE4]
            undervoltage_lockout_en <= operating_mode_control[`ADCR_BIT_BSRC]; // see [RULE4]
            // Threshold default only applies with the battery rail selected.
            if (!operating_mode_control[`ADCR_BIT_BSRC])
                brownout_threshold_mv <= `ADCR_BOP_DEF_MV; // see [RULE5]
            current_sense_powerdown <= operating_mode_control[`ADCR_BIT_ISNS]; // see [RULE6]
            voltage_sense_powerdown <= operating_mode_control[`ADCR_BIT_VSNS]; // see [RULE7]
            amp_active     <= 1'b0;
            amp_mute       <= 1'b0;
            amp_shutdown   <= 1'b0;
            diag_generator <= 1'b0;
            case (mode_field) // see [RULE8]
                `ADCR_M_ACTIVE:
                    amp_active <= 1'b1;
                `ADCR_M_MUTE:
                begin
                    amp_active <= 1'b1;
                    amp_mute   <= 1'b1;
                end
                `ADCR_M_GEN:
                    diag_generator <= 1'b1;
                `ADCR_M_DIAG_UP:
                    // Powers up only once the diagnostic has run.
                    amp_active <= !diag_running && !powerup_pending; // see [RULE9]
                `ADCR_M_DIAG_ONLY:
                    amp_shutdown <= 1'b0;
                default:
                    amp_shutdown <= 1'b1;
            endcase
        end
    end

    // Read channel; other pages and unmapped offsets read zero.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == `ADCR_OFS_PAGE)
                s_axi_rdata <= {24'h000000, page_select}; // see [RULE13]
            else if (s_axi_araddr == `ADCR_OFS_SRST)
                s_axi_rdata <= 32'h0000_0000; // see [RULE3]
            else if (s_axi_araddr == `ADCR_OFS_MODE)
            begin
                if (page_select == 8'h00)
                    s_axi_rdata <= {24'h000000, operating_mode_control};
            end
            else
                s_axi_rresp <= 2'h2;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // adcr_regs

// ---- sim/adcr_chk.sv ----
`timescale 1ns/1ps
// Watches the control outputs of the register bank against their causes.
module adcr_chk (
    // Clock and reset.
    input wire        clock,
    input wire        rst_n,
    // Diagnostic handshake.
    input wire        diag_done,
    input wire        diag_running,
    // Controls to the device.
    input wire        soft_reset_pulse,
    input wire        brownout_source_select,
    input wire        undervoltage_lockout_en,
    input wire [11:0] brownout_threshold_mv,
    input wire        current_sense_powerdown,
    input wire        voltage_sense_powerdown,
    input wire        amp_active,
    input wire        amp_mute,
    input wire        amp_shutdown,
    input wire        diag_generator
);
    // One clock domain, so every check shares clock and reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_undervoltage_lockout_follow: assert property (brownout_source_select == undervoltage_lockout_en)
        else $error("Lockout enable differs from brownout source.");
    a_bop_default: assert property (!brownout_source_select |->
        brownout_threshold_mv == 12'd2750) else $error("Brownout default threshold wrong.");
    a_srst_len: assert property ($rose(soft_reset_pulse) |->
        soft_reset_pulse[*8] ##1 !soft_reset_pulse) else $error("Soft reset pulse length wrong.");
    a_srst_restore: assert property (soft_reset_pulse[*3] |-> amp_shutdown &&
        current_sense_powerdown && voltage_sense_powerdown) else $error("Soft reset no restore.");
    a_reset_state: assert property ($rose(rst_n) |-> amp_shutdown &&
        current_sense_powerdown && voltage_sense_powerdown && !brownout_source_select)
        else $error("Outputs after reset wrong.");
    a_shdn_excl: assert property (amp_shutdown |->
        !amp_active && !amp_mute && !diag_generator) else $error("Shutdown overlaps other mode.");
    a_diag_hold: assert property (diag_running && !diag_done |=> diag_running)
        else $error("Diagnostic ended without completion.");
    a_diag_exit: assert property (diag_running && diag_done |=>
        !diag_running ##[1:3] (amp_shutdown || amp_active)) else $error("Diagnostic exit wrong.");
endmodule // adcr_chk

bind adcr_regs adcr_chk i_chk (.clock(clock), .rst_n(rst_n), .diag_done(diag_done),
    .diag_running(diag_running), .soft_reset_pulse(soft_reset_pulse),
    .brownout_source_select(brownout_source_select),
    .undervoltage_lockout_en(undervoltage_lockout_en),
    .brownout_threshold_mv(brownout_threshold_mv),
    .current_sense_powerdown(current_sense_powerdown),
    .voltage_sense_powerdown(voltage_sense_powerdown), .amp_active(amp_active),
    .amp_mute(amp_mute), .amp_shutdown(amp_shutdown), .diag_generator(diag_generator));

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`define ADCR_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// Drives the register bank over its bus and judges the control outputs.
module tb_top;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic        diag_done = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  page;
    wire  [11:0] thr;
    wire         running, srst, bsrc, undervoltage_lockout, isns, vsns, act, mute, shdn, gen;
    logic [1:0]  rsp;
    int          err_total = 0;
    int          num_checks = 0;

    // The bus runs at 125 MHz.
    always #4 clock = ~clock;

    adcr_regs i_dut (.clock(clock), .rst_n(rst_n), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .diag_done(diag_done), .diag_running(running), .page(page),
        .soft_reset_pulse(srst), .brownout_source_select(bsrc),
        .undervoltage_lockout_en(undervoltage_lockout), .brownout_threshold_mv(thr),
        .current_sense_powerdown(isns), .voltage_sense_powerdown(vsns),
        .amp_active(act), .amp_mute(mute), .amp_shutdown(shdn), .diag_generator(gen));

    // Handshakes are judged at the falling edge, where the values are those the next
    // rising edge will sample, so no race with the slave's own updates can occur.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int   n;
        tb = 1'b0;
        n = 0;
        @(posedge clock);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!tb && n < 200) begin
            @(negedge clock);
            ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready;
            rsp = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            n++;
        end
        `ADCR_CHK(tb, 1'b1)
        // Every write in this bench targets a mapped register.
        `ADCR_CHK(rsp, 2'b00)
    endtask

    // Reads one word and compares data and response.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ta, tr;
        int   n;
        tr = 1'b0;
        n = 0;
        @(posedge clock);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!tr && n < 200) begin
            @(negedge clock);
            ta = arvalid && arready; tr = rvalid && rready; rdat = rdata; rsp = rresp;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            n++;
        end
        `ADCR_CHK(rdat, e)
        `ADCR_CHK(rsp, r)
    endtask

    // Lets decoded outputs settle after a write.
    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask

    // Reset values of all three registers and of the shutdown, sense and source outputs.
    task automatic t_reset;
        rd(8'h00, 32'h0, 2'b00);
        rd(8'h04, 32'h0, 2'b00);
        rd(8'h08, 32'h1a, 2'b00);
        `ADCR_CHK({shdn, isns, vsns, bsrc}, 4'b1110)
        rd(8'h0c, 32'h0, 2'b10);
    endtask

    // Top page: selector stays reachable, mode hidden and not writable there.
    task automatic t_page;
        wr(8'h00, 32'hff);
        rd(8'h00, 32'hff, 2'b00);
        `ADCR_CHK(page, 8'hff)
        wr(8'h08, 32'h00);
        rd(8'h08, 32'h0, 2'b00);
        wr(8'h00, 32'h00);
        rd(8'h08, 32'h1a, 2'b00);
    endtask

    // Non-diagnostic mode codes other than 7, with the source and sense bits toggled.
    task automatic t_modes;
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
        logic [2:0] c;
        foreach (codes[i]) begin
            c = codes[i];
            wr(8'h08, {24'h0, (c[0] ? 8'h98 : 8'h00) | {5'h0, c}});
            settle(2);
            `ADCR_CHK({bsrc, undervoltage_lockout, isns, vsns}, {4{c[0]}})
            `ADCR_CHK(thr, 12'd2750)
            `ADCR_CHK({mute, shdn, gen}, {c == 3'h1, c == 3'h2 || c == 3'h6, c == 3'h5})
            `ADCR_CHK(act, (c == 3'h0) || (c == 3'h1))
        end
    endtask

    // Runs one diagnostic and reports its completion a few cycles later.
    task automatic diag(input logic [2:0] c);
        wr(8'h08, {29'h0, c});
        settle(2);
        `ADCR_CHK(running, 1'b1)
        @(posedge clock);
        diag_done <= 1'b1;
        @(posedge clock);
        diag_done <= 1'b0;
        settle(4);
        `ADCR_CHK(running, 1'b0)
    endtask

    // Standalone and power-up diagnostics.
    task automatic t_diag;
        diag(3'h4);
        rd(8'h08, 32'h02, 2'b00);
        diag(3'h3);
        `ADCR_CHK({act, shdn}, 2'b10)
    endtask

    // Soft reset pulses, clears its own bit and restores the mode register.
    task automatic t_srst;
        wr(8'h04, 32'h1);
        settle(2);
        `ADCR_CHK(srst, 1'b1)
        settle(10);
        `ADCR_CHK(srst, 1'b0)
        rd(8'h04, 32'h0, 2'b00);
        rd(8'h08, 32'h1a, 2'b00);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence after a 16-cycle reset.
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_page;
        t_modes;
        t_diag;
        t_srst;
        end_sim;
    end

    // Cuts a hang short; the tests need well under this span.
    initial
    begin
        #400000;
        err_total++;
        end_sim;
    end
endmodule // tb_top
